/* tb/pcs_hwy_model.sv */
// Behavioural PCM highway partner: bit clock, frame syncs and receive data.
module pcs_hwy_model (
    // Highway drive
    output logic      o_bclk,
    output logic      o_fs_tx,
    output logic      o_fs_rx,
    output logic      o_rx_data,
    // Device transmit side
    input  wire logic i_tx_out,
    input  wire logic i_tx_oe,
    input  wire logic i_stb_out,
    input  wire logic i_stb_oe
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        o_bclk = 1'b0;
        o_fs_tx = 1'b0;
        o_fs_rx = 1'b0;
        o_rx_data = 1'b1;
    end

    // ======================================================================
    // One frame of n bit clocks; the clock stands still between frames
    // A bit period of 25 system clocks keeps the bit clock locked to the system clock
    task automatic frame(input int rx_st, input int n, input logic [7:0] rx_b,
                         output logic [7:0] tx_b, output int oe_cnt, output int oe_first);
        oe_cnt = 0;
        oe_first = -1;
        tx_b = 8'h00;
        o_fs_tx = 1'b1;
        o_fs_rx = 1'b1;
        for (int i = 0; i < n; i++) begin
            #125 o_bclk = 1'b1;
            // Released line toggles so a stale value cannot pass for data
            if (i >= rx_st && i < rx_st + 8) o_rx_data = rx_b[7 - (i - rx_st)];
            else o_rx_data = ~o_rx_data;
            #100;
            if (i_tx_oe === 1'b1 && i_stb_oe === 1'b1 && i_stb_out === 1'b0) begin
                if (oe_cnt == 0) oe_first = i;
                oe_cnt++;
                tx_b = {tx_b[6:0], i_tx_out};
            end
            #25 o_bclk = 1'b0;
            o_fs_tx = 1'b0;
            o_fs_rx = 1'b0;
        end
        #125;
    endtask
endmodule

/* tb/pcs_top_tb.sv */
// Self-checking bench for the PCM codec serial ports.
`include "pcs_params.svh"
module pcs_top_tb;
    timeunit 1ns;
    timeprecision 100ps;

    logic       clk = 1'b0;
    logic       nrst = 1'b0;
    logic       control_clock = 1'b0;
    logic       cs_n = 1'b1;
    logic       cin = 1'b0;
    logic [3:0] pins_drv = 4'h5;
    logic [7:0] tx_byte = 8'hc5;
    wire logic  bclk, fs_tx, fs_rx, rx_data, tx_out, tx_oe, stb_out, stb_oe;
    wire logic  cout, cout_oe, rx_valid, pwr_dn;
    wire logic [3:0] pins_out, pins_oe, pin_lvl;
    wire logic [7:0] rx_byte;
    int         fails = 0;
    int         total_checks = 0;
    int         cycles = 0;
    int         valids = 0;

    assign pin_lvl = (pins_oe & pins_out) | (~pins_oe & pins_drv);

    pcs_top i_pcs_top (
        .I_CLK(clk), .I_NRST(nrst), .I_BCLK(bclk), .I_TX_FRAME_SYNC(fs_tx), .I_RX_FRAME_SYNC(fs_rx),
        .I_RX_PCM_IN(rx_data), .O_TX_PCM_OUT(tx_out), .O_TX_PCM_OUT_OE(tx_oe),
        .O_TX_SLOT_STROBE_N_OUT(stb_out), .O_TX_SLOT_STROBE_N_OE(stb_oe),
        .I_CONTROL_CLOCK(control_clock), .I_CONTROL_CS_N(cs_n), .I_CONTROL_IN(cin), .O_CONTROL_OUT(cout),
        .O_CONTROL_OUT_OE(cout_oe), .I_SLIC_LATCH_PINS(pin_lvl), .O_SLIC_LATCH_PINS(pins_out),
        .O_SLIC_LATCH_PINS_OE(pins_oe), .I_TX_PCM_BYTE(tx_byte), .O_RX_PCM_BYTE(rx_byte),
        .O_RX_PCM_VALID(rx_valid), .O_POWER_DOWN(pwr_dn));

    pcs_hwy_model i_pcs_hwy_model (
        .o_bclk(bclk), .o_fs_tx(fs_tx), .o_fs_rx(fs_rx), .o_rx_data(rx_data),
        .i_tx_out(tx_out), .i_tx_oe(tx_oe), .i_stb_out(stb_out), .i_stb_oe(stb_oe));

    // ======================================================================
    // Clock, timeout, receive pulse count
    always #5 clk = ~clk;

    always @(posedge clk) begin
        cycles++;
        if (rx_valid === 1'b1) valids++;
        if (cycles == 40000) begin
            fails++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        if (fails == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // ======================================================================
    // Control port transfers; control clock at 6 ns runs only with CS low
    task automatic ctrl(input logic [7:0] b1, input logic [7:0] wb, input int nb,
                        output logic [7:0] rb, output int oes);
        logic [15:0] sh;
        sh = {b1, wb};
        rb = 8'h00;
        oes = 0;
        @(posedge clk) cs_n <= 1'b0;
        #1.7;
        for (int i = 0; i < nb; i++) begin
            cin = sh[15 - i];
            #3 control_clock = 1'b1;
            #3 control_clock = 1'b0;
            if (i >= 7 && i < 15) begin
                if (cout_oe === 1'b1) oes++;
                rb = {rb[6:0], cout};
            end
        end
        #3;
        @(posedge clk) cs_n <= 1'b1;
        // Let the configuration cross before anything depends on it
        repeat (8) @(posedge clk);
    endtask

    function automatic logic [7:0] cmd(input logic [3:0] a, input logic rd);
        return {1'b0, a, rd, 1'b1, 1'b0};
    endfunction

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic [7:0] rb;
        int         oes;
        ctrl(cmd(a, 1'b0), d, 16, rb, oes);
        chk(oes, 0);
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] rb);
        int oes;
        ctrl(cmd(a, 1'b1), 8'h00, 16, rb, oes);
        chk(oes, 8);
    endtask

    // ======================================================================
    // Main sequence
    initial begin
        logic [7:0] rb, txb;
        int         oe_cnt, oe_first, v0;
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        chk(cout_oe, 1'b0);
        chk(pins_oe, `PCS_DIR_RESET);
        chk(pwr_dn, `PCS_POWER_RESET);
        i_pcs_hwy_model.frame(0, 10, 8'h3a, txb, oe_cnt, oe_first);
        chk(oe_cnt, 0);
        wr(`PCS_ADDR_DIR, 8'h03);
        wr(`PCS_ADDR_LATCH, 8'h0a);
        rd(`PCS_ADDR_DIR, rb);
        chk(rb, 8'h03);
        chk(pins_oe, 4'h3);
        chk(pins_out & pins_oe, 4'h2);
        rd(`PCS_ADDR_LATCH, rb);
        chk(rb[3:0], 4'h6);
        rd(4'h5, rb);
        chk(rb, 8'h00);
        chk(pwr_dn, 1'b0);
        v0 = valids;
        i_pcs_hwy_model.frame(0, 10, 8'h3a, txb, oe_cnt, oe_first);
        chk(txb, 8'hc5);
        chk(oe_cnt, 8);
        chk(oe_first, 0);
        chk(rx_byte, 8'h3a);
        chk(valids - v0, 1);
        wr(`PCS_ADDR_CTRL, 8'h01);
        wr(`PCS_ADDR_TX_SLOT, 8'h01);
        wr(`PCS_ADDR_RX_SLOT, 8'h02);
        rd(`PCS_ADDR_CTRL, rb);
        chk(rb, 8'h01);
        rd(`PCS_ADDR_TX_SLOT, rb);
        chk(rb, 8'h01);
        rd(`PCS_ADDR_RX_SLOT, rb);
        chk(rb, 8'h02);
        @(posedge clk) tx_byte <= 8'h96;
        i_pcs_hwy_model.frame(17, 27, 8'h5c, txb, oe_cnt, oe_first);
        chk(oe_first, 9);
        chk(txb, 8'h96);
        chk(oe_cnt, 8);
        chk(rx_byte, 8'h5c);
        ctrl(8'h80, 8'h00, 8, rb, oe_cnt);
        chk(pwr_dn, 1'b1);
        chk(pins_oe, 4'h3);
        i_pcs_hwy_model.frame(0, 27, 8'h00, txb, oe_cnt, oe_first);
        chk(oe_cnt, 0);
        tally_and_finish();
    end
endmodule

/* verilog/pcs_params.svh */
// Constants for the PCM codec serial ports: command fields, addresses, reset values.
`ifndef PCS_PARAMS_SVH
`define PCS_PARAMS_SVH

// ==========================================================================
// First control byte fields
`define PCS_CMD_POWER_BIT      7
`define PCS_ADDR_MSB           6
`define PCS_ADDR_LSB           3
`define PCS_CMD_READ_BIT       2
`define PCS_CMD_TWO_BYTE_BIT   1

// ==========================================================================
// Register addresses carried in the first byte
`define PCS_ADDR_CTRL          4'h0
`define PCS_ADDR_LATCH         4'h1
`define PCS_ADDR_DIR           4'h2
`define PCS_ADDR_RX_SLOT       4'h9
`define PCS_ADDR_TX_SLOT       4'ha

// ==========================================================================
// Control register layout and reset values
`define PCS_CTRL_DELAYED_BIT   0
`define PCS_CTRL_RESET         8'h00
`define PCS_DIR_RESET          4'h0
`define PCS_LATCH_RESET        4'h0
`define PCS_SLOT_RESET         6'h00
`define PCS_POWER_RESET        1'b1

// ==========================================================================
// Control port bit counter
`define PCS_BYTE1_LAST         5'h07
`define PCS_BYTE2_LAST         5'h0f
`define PCS_CNT_DONE           5'h10
`define PCS_CNT_BYTE2_FIRST    5'h08

// ==========================================================================
// PCM framing
`define PCS_FRAME_CNT_IDLE     10'h3ff
`define PCS_SLOT_BITS          10'h008
`define PCS_DELAY_BITS         10'h001
`define PCS_PIN_BCLK           0
`define PCS_PIN_FS_BASE        1
`define PCS_PIN_RX_DATA        3

`endif

/* verilog/pcs_pkg.sv */
// Types shared by the PCM codec serial port logic.
package pcs_pkg;

    // ======================================================================
    // Configuration word passed from the control clock domain
    typedef struct packed {
        logic       power_down;
        logic       delayed;
        logic [5:0] tx_slot;
        logic [5:0] rx_slot;
    } pcs_cfg_t;

endpackage

/* verilog/pcs_top.sv */
// PCM time-slot port, serial control port and interface latches of a telephony codec.
`include "pcs_params.svh"

module pcs_top (
    // System clock and reset
    input  wire logic       I_CLK,
    input  wire logic       I_NRST,
    // PCM highway
    input  wire logic       I_BCLK,
    input  wire logic       I_TX_FRAME_SYNC,
    input  wire logic       I_RX_FRAME_SYNC,
    input  wire logic       I_RX_PCM_IN,
    output logic            O_TX_PCM_OUT,
    output logic            O_TX_PCM_OUT_OE,
    output logic            O_TX_SLOT_STROBE_N_OUT,
    output logic            O_TX_SLOT_STROBE_N_OE,
    // Serial control port
    input  wire logic       I_CONTROL_CLOCK,
    input  wire logic       I_CONTROL_CS_N,
    input  wire logic       I_CONTROL_IN,
    output logic            O_CONTROL_OUT,
    output logic            O_CONTROL_OUT_OE,
    // Interface latch pins
    input  wire logic [3:0] I_SLIC_LATCH_PINS,
    output logic      [3:0] O_SLIC_LATCH_PINS,
    output logic      [3:0] O_SLIC_LATCH_PINS_OE,
    // Codec side PCM data
    input  wire logic [7:0] I_TX_PCM_BYTE,
    output logic      [7:0] O_RX_PCM_BYTE,
    output logic            O_RX_PCM_VALID,
    output logic            O_POWER_DOWN
);

    // ======================================================================
    // Control clock domain: shift registers and bit counter
    logic [4:0]             cp_cnt_reg;
    logic [7:0]             cp_sr_reg;
    logic [7:0]             cp_cmd_reg;
    logic [7:0]             cp_out_reg;
    logic [7:0]             ctrl_reg;
    logic [3:0]             latch_reg;
    logic [3:0]             dir_reg;
    logic [5:0]             tx_slot_reg;
    logic [5:0]             rx_slot_reg;
    logic                   power_reg;
    logic                   cfg_tgl_reg;
    logic [3:0]             lp_s1_reg;
    logic [3:0]             lp_s2_reg;
    wire                    cp_clr;
    wire  [7:0]             sr_next;
    wire                    byte1_done;
    wire                    byte2_done;
    wire                    wr;
    wire  [3:0]             rd_addr;
    wire  [3:0]             wr_addr;
    wire  [3:0]             latch_cap;
    wire  [3:0]             latch_next;
    wire  [7:0]             rb_val;
    pcs_pkg::pcs_cfg_t      cfg_cc;

    // Counter is held clear while deselected, so a stalled control clock cannot leave a stale count
    assign cp_clr     = I_CONTROL_CS_N | ~I_NRST;
    assign sr_next    = {cp_sr_reg[6:0], I_CONTROL_IN};
    assign byte1_done = ~I_CONTROL_CS_N & (cp_cnt_reg == `PCS_BYTE1_LAST);
    assign byte2_done = ~I_CONTROL_CS_N & (cp_cnt_reg == `PCS_BYTE2_LAST);
    assign wr         = byte2_done & cp_cmd_reg[`PCS_CMD_TWO_BYTE_BIT] & ~cp_cmd_reg[`PCS_CMD_READ_BIT];
    assign rd_addr    = sr_next[`PCS_ADDR_MSB:`PCS_ADDR_LSB];
    assign wr_addr    = cp_cmd_reg[`PCS_ADDR_MSB:`PCS_ADDR_LSB];
    assign latch_cap  = (latch_reg & dir_reg) | (lp_s2_reg & ~dir_reg);

    assign latch_next = (wr && wr_addr == `PCS_ADDR_LATCH) ? ((sr_next[3:0] & dir_reg) | (lp_s2_reg & ~dir_reg)) :
                        (byte1_done || wr)                ? latch_cap : latch_reg;
    assign rb_val = (rd_addr == `PCS_ADDR_CTRL)    ? ctrl_reg :
                    (rd_addr == `PCS_ADDR_LATCH)   ? {4'h0, latch_cap} :
                    (rd_addr == `PCS_ADDR_DIR)     ? {4'h0, dir_reg} :
                    (rd_addr == `PCS_ADDR_RX_SLOT) ? {2'h0, rx_slot_reg} :
                    (rd_addr == `PCS_ADDR_TX_SLOT) ? {2'h0, tx_slot_reg} : 8'h00;

    always_ff @(posedge I_CONTROL_CLOCK or posedge cp_clr) begin
        if (cp_clr)
            cp_cnt_reg <= 5'h00;
        else if (cp_cnt_reg != `PCS_CNT_DONE)
            cp_cnt_reg <= cp_cnt_reg + 5'h01;
    end

    always_ff @(posedge I_CONTROL_CLOCK or negedge I_NRST) begin
        if (!I_NRST) begin
            cp_sr_reg  <= 8'h00;
            cp_cmd_reg <= 8'h00;
            cp_out_reg <= 8'h00;
        end else if (!I_CONTROL_CS_N) begin
            cp_sr_reg  <= sr_next;
            cp_cmd_reg <= byte1_done ? sr_next : cp_cmd_reg;
            cp_out_reg <= byte1_done ? rb_val : {cp_out_reg[6:0], 1'b0};
        end
    end

    always_ff @(posedge I_CONTROL_CLOCK or negedge I_NRST) begin
        if (!I_NRST) begin
            ctrl_reg    <= `PCS_CTRL_RESET;
            dir_reg     <= `PCS_DIR_RESET;
            latch_reg   <= `PCS_LATCH_RESET;
            tx_slot_reg <= `PCS_SLOT_RESET;
            rx_slot_reg <= `PCS_SLOT_RESET;
            power_reg   <= `PCS_POWER_RESET;
            cfg_tgl_reg <= 1'b0;
        end else begin
            latch_reg   <= latch_next;
            power_reg   <= byte1_done ? sr_next[`PCS_CMD_POWER_BIT] : power_reg;
            cfg_tgl_reg <= (byte1_done || wr) ? ~cfg_tgl_reg : cfg_tgl_reg;
            if (wr && wr_addr == `PCS_ADDR_CTRL)
                ctrl_reg <= sr_next;
            if (wr && wr_addr == `PCS_ADDR_DIR)
                dir_reg <= sr_next[3:0];
            if (wr && wr_addr == `PCS_ADDR_TX_SLOT)
                tx_slot_reg <= sr_next[5:0];
            if (wr && wr_addr == `PCS_ADDR_RX_SLOT)
                rx_slot_reg <= sr_next[5:0];
        end
    end

    // Latch pins are sampled on the control clock, since captures happen at the first byte of every control transfer and on writes
    always_ff @(posedge I_CONTROL_CLOCK or negedge I_NRST) begin
        if (!I_NRST) begin
            lp_s1_reg <= 4'h0;
            lp_s2_reg <= 4'h0;
        end else begin
            lp_s1_reg <= I_SLIC_LATCH_PINS;
            lp_s2_reg <= lp_s1_reg;
        end
    end

    assign O_CONTROL_OUT        = cp_out_reg[7];
    assign O_CONTROL_OUT_OE     = ~I_CONTROL_CS_N & cp_cmd_reg[`PCS_CMD_READ_BIT] & cp_cmd_reg[`PCS_CMD_TWO_BYTE_BIT]
                                  & (cp_cnt_reg >= `PCS_CNT_BYTE2_FIRST) & (cp_cnt_reg != `PCS_CNT_DONE);
    assign O_SLIC_LATCH_PINS    = latch_reg & dir_reg;
    assign O_SLIC_LATCH_PINS_OE = dir_reg;

    assign cfg_cc.power_down = power_reg;
    assign cfg_cc.delayed    = ctrl_reg[`PCS_CTRL_DELAYED_BIT];
    assign cfg_cc.tx_slot    = tx_slot_reg;
    assign cfg_cc.rx_slot    = rx_slot_reg;

    // ======================================================================
    // Configuration crossing into the system clock domain
    // The word is stable for many control clocks after the toggle flips, so it is taken whole
    logic                   tgl_s1_reg;
    logic                   tgl_s2_reg;
    logic                   tgl_last_reg;
    pcs_pkg::pcs_cfg_t      cfg_reg;
    wire                    cfg_load;

    assign cfg_load = tgl_s2_reg ^ tgl_last_reg;
    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            tgl_s1_reg   <= 1'b0;
            tgl_s2_reg   <= 1'b0;
            tgl_last_reg <= 1'b0;
            cfg_reg      <= '{power_down: `PCS_POWER_RESET, delayed: 1'b0,
                              tx_slot: `PCS_SLOT_RESET, rx_slot: `PCS_SLOT_RESET};
        end else begin
            tgl_s1_reg   <= cfg_tgl_reg;
            tgl_s2_reg   <= tgl_s1_reg;
            tgl_last_reg <= tgl_s2_reg;
            if (cfg_load)
                cfg_reg <= cfg_cc;
        end
    end
    assign O_POWER_DOWN = cfg_reg.power_down;

    // ======================================================================
    // PCM pin synchronisers and bit clock edges
    logic [3:0]             pin_s1_reg;
    logic [3:0]             pin_s2_reg;
    logic                   bclk_last_reg;
    wire                    bclk_rise;
    wire                    bclk_fall;

    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            pin_s1_reg    <= 4'h0;
            pin_s2_reg    <= 4'h0;
            bclk_last_reg <= 1'b0;
        end else begin
            pin_s1_reg    <= {I_RX_PCM_IN, I_RX_FRAME_SYNC, I_TX_FRAME_SYNC, I_BCLK};
            pin_s2_reg    <= pin_s1_reg;
            bclk_last_reg <= pin_s2_reg[`PCS_PIN_BCLK];
        end
    end

    assign bclk_rise = pin_s2_reg[`PCS_PIN_BCLK] & ~bclk_last_reg;
    assign bclk_fall = ~pin_s2_reg[`PCS_PIN_BCLK] & bclk_last_reg;

    // ======================================================================
    // Frame counters: channel 0 transmit, channel 1 receive
    for (genvar ch = 0; ch < 2; ch++) begin : gen_ch
        logic               fs_seen_reg;
        logic [9:0]         cnt_reg;
        wire                fs_edge;
        wire  [5:0]         slot;
        wire  [9:0]         base;
        wire  [9:0]         cnt_next;
        wire  [9:0]         off_now;
        wire  [9:0]         off_next;
        wire                act_now;
        wire                act_next;
        wire  [2:0]         idx_now;
        wire  [2:0]         idx_next;

        // Frame sync is judged at the bit clock, so a square wave and a pulse behave alike
        assign fs_edge  = pin_s2_reg[`PCS_PIN_FS_BASE + ch] & ~fs_seen_reg;
        assign slot     = (ch == 0) ? cfg_reg.tx_slot : cfg_reg.rx_slot;
        assign base     = cfg_reg.delayed ? ({1'b0, slot, 3'h0} + `PCS_DELAY_BITS) : 10'h000;
        assign cnt_next = fs_edge ? 10'h000 :
                          (cnt_reg == `PCS_FRAME_CNT_IDLE) ? cnt_reg : cnt_reg + 10'h001;
        assign off_now  = cnt_reg - base;
        assign off_next = cnt_next - base;
        assign act_now  = (cnt_reg != `PCS_FRAME_CNT_IDLE) & (cnt_reg >= base) & (off_now < `PCS_SLOT_BITS)
                          & ~cfg_reg.power_down;
        assign act_next = (cnt_next != `PCS_FRAME_CNT_IDLE) & (cnt_next >= base) & (off_next < `PCS_SLOT_BITS)
                          & ~cfg_reg.power_down;
        assign idx_now  = off_now[2:0];
        assign idx_next = off_next[2:0];

        always_ff @(posedge I_CLK or negedge I_NRST) begin
            if (!I_NRST) begin
                fs_seen_reg <= 1'b0;
                cnt_reg     <= `PCS_FRAME_CNT_IDLE;
            end else if (bclk_rise) begin
                fs_seen_reg <= pin_s2_reg[`PCS_PIN_FS_BASE + ch];
                cnt_reg     <= cnt_next;
            end
        end
    end

    // ======================================================================
    // Transmit shifter and slot strobe
    logic                   tx_oe_reg;
    logic                   tx_out_reg;
    logic [7:0]             tx_sh_reg;

    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            tx_oe_reg  <= 1'b0;
            tx_out_reg <= 1'b0;
            tx_sh_reg  <= 8'h00;
        end else if (bclk_rise) begin
            tx_oe_reg  <= gen_ch[0].act_next;
            tx_out_reg <= (gen_ch[0].idx_next == 3'h0) ? I_TX_PCM_BYTE[7] : tx_sh_reg[7];
            tx_sh_reg  <= (gen_ch[0].idx_next == 3'h0) ? {I_TX_PCM_BYTE[6:0], 1'b0} : {tx_sh_reg[6:0], 1'b0};
        end else if (cfg_reg.power_down) begin
            tx_oe_reg  <= 1'b0;
        end
    end

    assign O_TX_PCM_OUT           = tx_out_reg;
    assign O_TX_PCM_OUT_OE        = tx_oe_reg;
    assign O_TX_SLOT_STROBE_N_OUT = 1'b0;
    assign O_TX_SLOT_STROBE_N_OE  = tx_oe_reg;

    // ======================================================================
    // Receive shifter
    logic [7:0]             rx_sh_reg;
    logic [7:0]             rx_byte_reg;
    logic                   rx_valid_reg;
    wire                    rx_take;

    assign rx_take = bclk_fall & gen_ch[1].act_now;

    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            rx_sh_reg    <= 8'h00;
            rx_byte_reg  <= 8'h00;
            rx_valid_reg <= 1'b0;
        end else begin
            rx_sh_reg    <= rx_take ? {rx_sh_reg[6:0], pin_s2_reg[`PCS_PIN_RX_DATA]} : rx_sh_reg;
            rx_valid_reg <= rx_take & (gen_ch[1].idx_now == 3'h7);
            if (rx_take && gen_ch[1].idx_now == 3'h7)
                rx_byte_reg <= {rx_sh_reg[6:0], pin_s2_reg[`PCS_PIN_RX_DATA]};
        end
    end

    assign O_RX_PCM_BYTE  = rx_byte_reg;
    assign O_RX_PCM_VALID = rx_valid_reg;

    // ======================================================================
    // Checks
    logic [3:0]             tx_bits_reg;
    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST)
            tx_bits_reg <= 4'h0;
        else if (!tx_oe_reg)
            tx_bits_reg <= 4'h0;
        else if (bclk_rise)
            tx_bits_reg <= tx_bits_reg + 4'h1;
    end

    property p_tx_rise_on_bclk;
        @(posedge I_CLK) disable iff (!I_NRST) $rose(O_TX_PCM_OUT_OE) |-> $past(bclk_rise);
    endproperty
    a_tx_rise_on_bclk: assert property (p_tx_rise_on_bclk) else $error("Transmit drive began off a rising bit clock");
    // Mid-slot configuration writes are outside the intended use, so a changed word excuses one cycle
    property p_strobe_low;
        @(posedge I_CLK) disable iff (!I_NRST)
            O_TX_SLOT_STROBE_N_OE |-> (O_TX_SLOT_STROBE_N_OUT == 1'b0) && O_TX_PCM_OUT_OE
                                      && (gen_ch[0].act_now || $changed(cfg_reg));
    endproperty
    a_strobe_low: assert property (p_strobe_low) else $error("Slot strobe active outside transmit slot");
    property p_eight_bits;
        @(posedge I_CLK) disable iff (!I_NRST)
            ($fell(O_TX_PCM_OUT_OE) && !cfg_reg.power_down && !$past(gen_ch[0].fs_edge)) |-> $past(tx_bits_reg) == 4'h7;
    endproperty
    a_eight_bits: assert property (p_eight_bits) else $error("Transmit slot did not carry eight bits");
    property p_rx_on_fall;
        @(posedge I_CLK) disable iff (!I_NRST) O_RX_PCM_VALID |-> $past(bclk_fall) && $past(gen_ch[1].act_now);
    endproperty
    a_rx_on_fall: assert property (p_rx_on_fall) else $error("Receive byte completed off a falling bit clock");
    property p_frame_restart;
        @(posedge I_CLK) disable iff (!I_NRST) (bclk_rise && gen_ch[0].fs_edge) |=> gen_ch[0].cnt_reg == 10'h000;
    endproperty
    a_frame_restart: assert property (p_frame_restart) else $error("Frame counter not restarted by frame sync");
    property p_cfg_sync;
        @(posedge I_CLK) disable iff (!I_NRST) (cfg_reg != $past(cfg_reg)) |-> $past(cfg_load);
    endproperty
    a_cfg_sync: assert property (p_cfg_sync) else $error("Configuration changed without a synchronised load");
    property p_power_quiet;
        @(posedge I_CLK) disable iff (!I_NRST) cfg_reg.power_down |=> !O_TX_PCM_OUT_OE;
    endproperty
    a_power_quiet: assert property (p_power_quiet) else $error("Transmit driven while powered down");
    property p_readback;
        @(posedge I_CONTROL_CLOCK) disable iff (!I_NRST)
            (byte1_done && sr_next[`PCS_CMD_READ_BIT] && sr_next[`PCS_CMD_TWO_BYTE_BIT]) |=>
                O_CONTROL_OUT == $past(rb_val[7]) && O_CONTROL_OUT_OE;
    endproperty
    a_readback: assert property (p_readback) else $error("Read-back byte not presented on control output");
    property p_dir_write;
        @(posedge I_CONTROL_CLOCK) disable iff (!I_NRST)
            (wr && wr_addr == `PCS_ADDR_DIR) |=> O_SLIC_LATCH_PINS_OE == $past(sr_next[3:0]);
    endproperty
    a_dir_write: assert property (p_dir_write) else $error("Latch direction write not applied");
    property p_latch_write;
        @(posedge I_CONTROL_CLOCK) disable iff (!I_NRST)
            (wr && wr_addr == `PCS_ADDR_LATCH) |=>
                latch_reg == (($past(sr_next[3:0]) & dir_reg) | ($past(lp_s2_reg) & ~dir_reg));
    endproperty
    a_latch_write: assert property (p_latch_write) else $error("Latch write or input capture wrong");

endmodule
